// *** adc_parallel_conversion_control_tb_top.sv ***
// Self-checking bench for the conversion control block.
// Assumes the package, design, checker and host model compile first.
`timescale 1ns/1ps
module adc_parallel_conversion_control_tb_top;
	logic        clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        six;
	logic        comp;
	logic        cs_n, wr_n, rd_n, ext, oe, rdy_n, trk, conv, pd, sb, extm;
	logic [11:0] hbus, dout, din, dac, d;
	logic [2:0]  psel, nsel;
	int          error_cnt = 0;
	int          n_compared = 0;
	// Shared wire: block drives while its enable is high
	assign din = oe ? dout : hbus;
	always #5 clk_i = ~clk_i;
	apcc_host host (.clk_i(clk_i), .bus_i(din), .cs_n_o(cs_n), .wr_n_o(wr_n), .rd_n_o(rd_n),
		.bus_o(hbus), .ext_clk_o(ext));
	apcc_ctrl uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n), .wr_n_i(wr_n),
		.rd_n_i(rd_n), .ext_clk_i(ext), .data_i(din), .data_o(dout), .data_oe_o(oe),
		.ready_n_o(rdy_n), .six_inputs_i(six), .comp_i(comp), .track_o(trk),
		.pos_sel_o(psel), .neg_sel_o(nsel), .converting_o(conv), .dac_o(dac),
		.powered_down_o(pd), .standby_o(sb), .ext_clk_mode_o(extm));
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic wait_rdy();
		for (int i = 0; i < 1000 && rdy_n !== 1'b0; i++) @(posedge clk_i);
		settle(1);
		chk(12'(rdy_n), 12'h0);
	endtask
	task automatic t_conv(input logic [7:0] b, input logic [2:0] p, input logic [2:0] n,
		input logic [11:0] r);
		host.wr(b);
		settle(3);
		chk(12'(trk), 12'h1);
		chk(12'(psel), 12'(p));
		chk(12'(nsel), 12'(n));
		wait_rdy();
		host.rd(d);
		chk(d, r);
		settle(1);
		chk(12'(rdy_n), 12'h1);
	endtask
	task automatic t_por();
		settle(0);
		chk({rdy_n, extm, oe, 6'h0, nsel}, {3'h6, 9'h7});
		host.wr(8'hCA);
		settle(3);
		chk(12'(trk), 12'h0);
		settle(1000);
		$display("test por done");
	endtask
	task automatic t_format();
		logic [2:0] np [6] = '{3'h1, 3'h0, 3'h3, 3'h2, 3'h5, 3'h4};
		for (int c = 0; c < 6; c++) t_conv(8'hC8 | 8'(c), 3'(c), np[c], 12'hFFF);
		t_conv(8'hDC, 3'h4, 3'h7, 12'hFFF);
		@(posedge clk_i) comp <= 1'b0;
		t_conv(8'hC2, 3'h2, 3'h3, 12'h800);
		@(posedge clk_i) comp <= 1'b1;
		$display("test format done");
	endtask
	task automatic t_clock();
		t_conv(8'h8A, 3'h2, 3'h3, 12'hFFF);
		host.wr(8'hAA);
		settle(3);
		chk(12'({trk, conv, extm}), 12'h4);
		host.wr(8'h8A);
		wait_rdy();
		host.rd(d);
		chk(d, 12'hFFF);
		host.wr(8'h0A);
		settle(3);
		chk({trk, pd, extm}, 12'h2);
		host.wr(8'h4A);
		settle(3);
		chk({sb, extm}, 12'h2);
		t_conv(8'hCA, 3'h2, 3'h3, 12'hFFF);
		chk(12'(extm), 12'h1);
		$display("test clock done");
	endtask
	task automatic t_ext_acq();
		host.wr(8'hEA);
		settle(200);
		chk({trk, conv}, 12'h2);
		host.wr(8'hCA);
		settle(3);
		chk({trk, conv}, 12'h1);
		wait_rdy();
		host.wr(8'hEA);
		settle(1);
		chk(12'(rdy_n), 12'h1);
		host.wr(8'hCA);
		wait_rdy();
		host.rd(d);
		chk(d, 12'hFFF);
		$display("test external acquisition done");
	endtask
	task automatic t_gate();
		@(posedge clk_i) six <= 1'b0;
		host.wr(8'hCA);
		settle(3);
		chk(12'(trk), 12'h0);
		t_conv(8'hC8, 3'h0, 3'h1, 12'hFFF);
		@(posedge clk_i) six <= 1'b1;
		host.blk = 1'b1;
		host.wr(8'hCA);
		host.rd(d);
		settle(2);
		chk({trk, oe}, 12'h0);
		chk(12'(psel), 12'h0);
		host.blk = 1'b0;
		$display("test gating done");
	endtask
	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		six  <= 1'b1;
		comp <= 1'b1;
		repeat (12) @(posedge clk_i);
		rst_n_i <= 1'b1;
		t_por();
		t_format();
		t_clock();
		t_ext_acq();
		t_gate();
		close_out();
	end
	// Whole run needs about 6000 cycles; allow about eight times that
	initial begin
		#500000;
		error_cnt++;
		close_out();
	end
endmodule

// *** apcc_assertions.sv ***
// Checker for the conversion control block top ports.
// Assumes it is bound onto every apcc_ctrl instance.
`timescale 1ns/1ps
module apcc_assertions (
	// System
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Host side
	input wire logic cs_n_i,
	input wire logic wr_n_i,
	input wire logic rd_n_i,
	input wire logic ext_clk_i,
	input wire logic data_oe_o,
	input wire logic ready_n_o,
	// Core side
	input wire logic track_o,
	input wire logic converting_o,
	input wire logic ext_clk_mode_o
);
	localparam int POR = apcc_pkg::POR_CYCLES;
	logic [10:0] por_reg;
	logic [4:0]  falls_reg;
	logic        ext_q_reg;
	wire         fall = ext_q_reg && !ext_clk_i && !cs_n_i;
	// ------
	// Helpers
	// ------
	always_ff @(posedge clk_i) begin
		ext_q_reg <= ext_clk_i;
		por_reg   <= !rst_n_i ? 11'h0 : por_reg + 11'(por_reg != 11'h7FF);
		falls_reg <= (!rst_n_i || !converting_o) ? 5'h0 : falls_reg + 5'(fall);
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// ------
	// Checks
	// ------
	a_por_no_start: assert property (por_reg < POR |-> !track_o && !converting_o)
		else $error("start inside power-on window");
	a_reset_ext_mode: assert property ($rose(rst_n_i) |-> ext_clk_mode_o && ready_n_o)
		else $error("wrong state after reset");
	a_oe_on_read: assert property (!cs_n_i && !rd_n_i && wr_n_i |=> data_oe_o)
		else $error("read did not enable bus");
	a_idle_bus_hiz: assert property (cs_n_i |=> !data_oe_o)
		else $error("bus driven while deselected");
	a_ready_after_conv: assert property ($fell(ready_n_o) |->
		$past(converting_o) || $past(converting_o, 2)) else $error("ready without conversion");
	a_ready_read_clear: assert property (!ready_n_o && $fell(rd_n_i) && !cs_n_i
		&& !converting_o |-> ##[1:2] ready_n_o) else $error("read left ready low");
	a_hold_then_conv: assert property ($fell(track_o) |-> ##[0:2] converting_o)
		else $error("hold not followed by conversion");
	a_conv_thirteen: assert property ($fell(converting_o) && ext_clk_mode_o
		|-> falls_reg == 5'hD) else $error("conversion length wrong");
	c_ext_done: cover property ($fell(converting_o) && ext_clk_mode_o);
	c_int_done: cover property ($fell(converting_o) && !ext_clk_mode_o);
	c_read_clear: cover property (!ready_n_o ##1 ready_n_o);
endmodule
bind apcc_ctrl apcc_assertions u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n_i),
	.wr_n_i(wr_n_i), .rd_n_i(rd_n_i), .ext_clk_i(ext_clk_i), .data_oe_o(data_oe_o),
	.ready_n_o(ready_n_o), .track_o(track_o), .converting_o(converting_o),
	.ext_clk_mode_o(ext_clk_mode_o));

// *** apcc_clk_if.sv ***
// Conversion clock edges passed from the clock source to the sequencer.
// Assumes both ends run on clk_i.
`timescale 1ns/1ps
interface apcc_clk_if;
	logic fall;
	logic rise;
	logic use_ext;
	logic run;
	modport src  (input use_ext, input run, output fall, output rise);
	modport sink (output use_ext, output run, input fall, input rise);
endinterface

// *** apcc_clk_src.sv ***
// Conversion clock source: external pin edges or internal divider.
// Assumes the external clock pin is synchronous to clk_i.
`timescale 1ns/1ps
module apcc_clk_src (
	// System
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	// Pin and selection
	input  wire logic ext_clk_i,
	input  wire logic cs_n_i,
	apcc_clk_if.src   cif
);
	logic       ext_reg;
	logic       int_reg;
	logic [7:0] div_reg;
	logic       tick;
	logic       ext_fall;
	logic       ext_rise;
	logic       ext_now;

	// Pin ignored while deselected
	assign ext_now  = cs_n_i ? ext_reg : ext_clk_i;
	assign ext_fall = ext_reg & ~ext_now;
	assign ext_rise = ~ext_reg & ext_now;
	assign tick     = cif.run && (div_reg == 8'(apcc_pkg::INT_CLK_HALF_CYC - 1));
	assign cif.fall = cif.use_ext ? ext_fall : (tick & int_reg);
	assign cif.rise = cif.use_ext ? ext_rise : (tick & ~int_reg);

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ext_reg <= 1'b0;
			int_reg <= 1'b0;
			div_reg <= 8'h00;
		end else begin
			ext_reg <= ext_now;
			// Internal oscillator only runs during internal acquisition and conversion, in either clock mode
			div_reg <= (!cif.run || tick) ? 8'h00 : div_reg + 8'h01;
			int_reg <= !cif.run ? 1'b0 : (tick ? ~int_reg : int_reg);
		end
	end
endmodule

// *** apcc_ctrl.sv ***
// Conversion control: control byte, track/hold, 13-cycle conversion, ready flag.
// Assumes host strobes synchronous to clk_i; analog core is driven by outputs.
`timescale 1ns/1ps
module apcc_ctrl (
	// System
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	// Host bus
	input  wire logic        cs_n_i,
	input  wire logic        wr_n_i,
	input  wire logic        rd_n_i,
	input  wire logic        ext_clk_i,
	input  wire logic [11:0] data_i,
	output logic      [11:0] data_o,
	output logic             data_oe_o,
	output logic             ready_n_o,
	// Variant strap, high for six inputs
	input  wire logic        six_inputs_i,
	// Analog core
	input  wire logic        comp_i,
	output logic             track_o,
	output logic [2:0]       pos_sel_o,
	output logic [2:0]       neg_sel_o,
	output logic             converting_o,
	output logic [11:0]      dac_o,
	output logic             powered_down_o,
	output logic             standby_o,
	output logic             ext_clk_mode_o
);
	apcc_clk_if cif ();

	apcc_clk_src u_clk (
		.clk_i     (clk_i),
		.rst_n_i   (rst_n_i),
		.ext_clk_i (ext_clk_i),
		.cs_n_i    (cs_n_i),
		.cif       (cif.src)
	);

	// ------------------------------------------------------------
	// Host strobes
	// ------------------------------------------------------------
	apcc_pkg::apcc_state_t state_reg;
	apcc_pkg::apcc_state_t state_next;
	logic [7:0]  ctl_reg;
	logic        wr_reg;
	logic        rd_reg;
	logic        ext_mode_reg;
	logic [3:0]  cnt_reg;
	logic [11:0] sar_reg;
	logic [11:0] result_reg;
	logic [11:0] trial_reg;
	logic [10:0] por_reg;
	logic        por_done;
	logic        wr_rise;
	logic        rd_fall;
	logic        wr_low;
	logic        rd_low;

	// Strobes only seen with chip select low
	assign wr_low  = ~cs_n_i & ~wr_n_i;
	assign rd_low  = ~cs_n_i & ~rd_n_i;
	assign wr_rise = wr_reg & ~wr_low & ~cs_n_i;
	assign rd_fall = ~rd_reg & rd_low;
	assign por_done = (por_reg == 11'(apcc_pkg::POR_CYCLES));

	// ------------------------------------------------------------
	// Control byte decode
	// ------------------------------------------------------------
	logic [1:0] pwr_bits;
	logic       win_bit;
	logic       pair_bit;
	logic       pol_bit;
	logic [2:0] code_bits;
	logic       new_pwr_on;
	logic       new_ext_clk;
	logic       code_ok;

	assign pwr_bits  = data_i[apcc_pkg::CTL_PWR_HI:apcc_pkg::CTL_PWR_LO];
	assign win_bit   = data_i[apcc_pkg::CTL_WINDOW];
	assign pair_bit  = data_i[apcc_pkg::CTL_PAIRING];
	assign pol_bit   = data_i[apcc_pkg::CTL_POLARITY];
	assign code_bits = data_i[apcc_pkg::CTL_CODE_MSB:0];
	assign new_pwr_on = pwr_bits[1];
	// Power-down byte keeps previous clock choice
	assign new_ext_clk = new_pwr_on ? pwr_bits[0] : ext_mode_reg;
	// Codes beyond the first pair need the six-input variant
	assign code_ok = six_inputs_i || (code_bits[2:1] == 2'b00);

	// ------------------------------------------------------------
	// Multiplexer selection
	// ------------------------------------------------------------
	logic [2:0] sel_code;
	logic [2:0] pos_sel;
	logic [2:0] pair_neg;
	logic [2:0] neg_sel;

	assign sel_code = ctl_reg[apcc_pkg::CTL_CODE_MSB:0];
	assign pos_sel  = (sel_code > 3'h5) ? 3'h0 : sel_code;
	// Partner is the other input of the same pair
	assign pair_neg = {pos_sel[2:1], ~pos_sel[0]};
	assign neg_sel  = ctl_reg[apcc_pkg::CTL_PAIRING] ? apcc_pkg::COMMON_SEL : pair_neg;

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	logic start_write;
	logic last_bit;
	logic sample_now;
	logic cnt_clear;

	assign start_write = wr_rise && por_done && code_ok && new_pwr_on;
	assign last_bit    = (cnt_reg == 4'(apcc_pkg::CONV_CYCLES - 1));
	assign sample_now  = cif.fall && (cnt_reg == 4'(apcc_pkg::HOLD_EDGE - 1));
	// A restarted internal window times its four edges afresh
	assign cnt_clear   = (state_next != state_reg) ||
	                     (start_write && state_reg == apcc_pkg::APCC_ACQ_INT);
	assign cif.use_ext = ext_mode_reg;
	assign cif.run     = (state_reg == apcc_pkg::APCC_ACQ_INT) ||
	                     (state_reg == apcc_pkg::APCC_CONV);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			apcc_pkg::APCC_IDLE: begin
				if (start_write && win_bit) begin
					state_next = apcc_pkg::APCC_ACQ_EXT;
				end else if (start_write) begin
					state_next = apcc_pkg::APCC_ACQ_INT;
				end
			end
			apcc_pkg::APCC_ACQ_INT: begin
				if (sample_now) begin
					state_next = apcc_pkg::APCC_CONV;
				end
			end
			apcc_pkg::APCC_ACQ_EXT: begin
				if (wr_rise && !win_bit) begin
					state_next = apcc_pkg::APCC_CONV;
				end
			end
			apcc_pkg::APCC_CONV: begin
				if (cif.fall && last_bit) begin
					state_next = apcc_pkg::APCC_IDLE;
				end
			end
			default: state_next = apcc_pkg::APCC_IDLE;
		endcase
		// A new write during internal acquisition restarts acquisition, external when the window bit is set
		if (state_reg != apcc_pkg::APCC_CONV && state_reg != apcc_pkg::APCC_ACQ_EXT &&
		    state_reg != apcc_pkg::APCC_IDLE && start_write) begin
			state_next = win_bit ? apcc_pkg::APCC_ACQ_EXT : apcc_pkg::APCC_ACQ_INT;
		end
	end

	// ------------------------------------------------------------
	// Result formatting
	// ------------------------------------------------------------
	logic [11:0] sar_next;
	logic [11:0] out_word;

	assign sar_next = comp_i ? sar_reg : (sar_reg & ~trial_reg);
	// Bipolar output is offset binary with the top bit inverted
	assign out_word = ctl_reg[apcc_pkg::CTL_POLARITY] ? result_reg
	                : {~result_reg[11], result_reg[10:0]};

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state_reg    <= apcc_pkg::APCC_IDLE;
			ctl_reg      <= apcc_pkg::CTL_RESET;
			wr_reg       <= 1'b0;
			rd_reg       <= 1'b0;
			ext_mode_reg <= 1'b1;
			cnt_reg      <= 4'h0;
			sar_reg      <= 12'h000;
			trial_reg    <= 12'h000;
			result_reg   <= 12'h000;
			por_reg      <= 11'h000;
		end else begin
			state_reg <= state_next;
			wr_reg    <= wr_low;
			rd_reg    <= rd_low;
			if (!por_done) begin
				por_reg <= por_reg + 11'h001;
			end
			if (wr_rise) begin
				ctl_reg      <= data_i[7:0];
				ext_mode_reg <= new_ext_clk;
			end
			if (cnt_clear) begin
				cnt_reg <= 4'h0;
			end else if (cif.fall && state_reg != apcc_pkg::APCC_IDLE) begin
				cnt_reg <= cnt_reg + 4'h1;
			end
			if (state_next == apcc_pkg::APCC_CONV && state_reg != apcc_pkg::APCC_CONV) begin
				sar_reg   <= 12'h800;
				trial_reg <= 12'h800;
			end else if (state_reg == apcc_pkg::APCC_CONV && cif.fall && cnt_reg != 4'h0 &&
			             trial_reg != 12'h000) begin
				sar_reg   <= sar_next | {1'b0, trial_reg[11:1]};
				trial_reg <= {1'b0, trial_reg[11:1]};
			end
			if (state_reg == apcc_pkg::APCC_CONV && state_next == apcc_pkg::APCC_IDLE) begin
				// Last bit decision is folded in as the word is taken
				result_reg <= sar_next;
			end
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	logic conv_done;
	logic ready_clear;
	logic oe_next;
	logic track_next;
	logic conv_next;
	logic idle_now;
	logic pd_next;
	logic sb_next;

	assign conv_done   = (state_reg == apcc_pkg::APCC_CONV) &&
	                     (state_next == apcc_pkg::APCC_IDLE);
	assign ready_clear = rd_fall || wr_rise;
	assign oe_next     = rd_low && wr_n_i;
	assign track_next  = (state_next == apcc_pkg::APCC_ACQ_INT) ||
	                     (state_next == apcc_pkg::APCC_ACQ_EXT);
	assign conv_next   = (state_next == apcc_pkg::APCC_CONV);
	assign idle_now    = (state_reg == apcc_pkg::APCC_IDLE);
	// Low-power states only show once the converter has gone idle
	assign pd_next     = (ctl_reg[7:6] == 2'b00) && idle_now;
	assign sb_next     = (ctl_reg[7:6] == 2'b01) && idle_now;

	// Completion wins over a same-cycle read so no result is lost
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ready_n_o <= 1'b1;
		end else if (conv_done) begin
			ready_n_o <= 1'b0;
		end else if (ready_clear) begin
			ready_n_o <= 1'b1;
		end
	end

	// Host data bus
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			data_o    <= 12'h000;
			data_oe_o <= 1'b0;
		end else begin
			data_o    <= out_word;
			data_oe_o <= oe_next;
		end
	end

	// Analog core controls
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			track_o      <= 1'b0;
			pos_sel_o    <= 3'h0;
			neg_sel_o    <= apcc_pkg::COMMON_SEL;
			converting_o <= 1'b0;
			dac_o        <= 12'h000;
		end else begin
			track_o      <= track_next;
			pos_sel_o    <= pos_sel;
			neg_sel_o    <= neg_sel;
			converting_o <= conv_next;
			dac_o        <= sar_reg;
		end
	end

	// Power and clock status
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			powered_down_o <= 1'b0;
			standby_o      <= 1'b0;
			ext_clk_mode_o <= 1'b1;
		end else begin
			powered_down_o <= pd_next;
			standby_o      <= sb_next;
			ext_clk_mode_o <= ext_mode_reg;
		end
	end
endmodule

// *** apcc_host.sv ***
// Host processor model driving strobes, bus and conversion clock.
// Assumes the block samples every strobe on clk_i.
`timescale 1ns/1ps
module apcc_host (
	// System
	input  wire logic        clk_i,
	// Bus
	input  wire logic [11:0] bus_i,
	output logic             cs_n_o,
	output logic             wr_n_o,
	output logic             rd_n_o,
	output logic [11:0]      bus_o,
	output logic             ext_clk_o
);
	logic       blk = 1'b0;
	logic [4:0] div = 5'h0;
	// Idle bus levels before the first task runs
	initial begin
		cs_n_o = 1'b0;
		wr_n_o = 1'b1;
		rd_n_o = 1'b1;
		bus_o  = 12'h000;
	end
	// Free 5 MHz clock, 50 percent duty; chip select idles low so it counts
	always @(posedge clk_i) begin
		div       <= (div == 5'h13) ? 5'h0 : div + 5'h1;
		ext_clk_o <= (div < 5'hA);
	end
	task automatic wr(input logic [7:0] b);
		@(posedge clk_i);
		cs_n_o <= blk;
		wr_n_o <= 1'b0;
		bus_o  <= {4'h0, b};
		@(posedge clk_i);
		wr_n_o <= 1'b1;
		@(posedge clk_i);
		bus_o  <= ~bus_o;
		cs_n_o <= 1'b0;
	endtask
	task automatic rd(output logic [11:0] d);
		@(posedge clk_i);
		cs_n_o <= blk;
		rd_n_o <= 1'b0;
		repeat (2) @(posedge clk_i);
		d = bus_i;
		rd_n_o <= 1'b1;
		cs_n_o <= 1'b0;
	endtask
endmodule

// *** apcc_pkg.sv ***
// Package for the converter conversion control block.
// Assumes a single 100 MHz clock domain; no imports are made by users.
package apcc_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS       = 10;
	localparam int INT_CLK_PERIOD_NS   = 280;
	localparam int INT_CLK_HALF_CYC    = INT_CLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
	localparam int ACQ_CYCLES          = 3;
	localparam int HOLD_EDGE           = 4;
	localparam int CONV_CYCLES         = 13;
	localparam int POR_TIME_NS         = 10000;
	localparam int POR_CYCLES          = POR_TIME_NS / CLK_PERIOD_NS;

	// ------------------------------------------------------------
	// Control byte fields
	// ------------------------------------------------------------
	localparam int CTL_PWR_HI          = 7;
	localparam int CTL_PWR_LO          = 6;
	localparam int CTL_WINDOW          = 5;
	localparam int CTL_PAIRING         = 4;
	localparam int CTL_POLARITY        = 3;
	localparam int CTL_CODE_MSB        = 2;
	localparam int RESULT_W            = 12;
	localparam int NUM_INPUTS          = 6;
	localparam logic [7:0] CTL_RESET   = 8'hC8;
	localparam logic [2:0] COMMON_SEL  = 3'h7;

	typedef enum logic [1:0] {
		APCC_PWR_OFF,
		APCC_PWR_STBY,
		APCC_PWR_INT,
		APCC_PWR_EXT
	} apcc_pwr_t;

	typedef enum logic [2:0] {
		APCC_IDLE,
		APCC_ACQ_INT,
		APCC_ACQ_EXT,
		APCC_CONV
	} apcc_state_t;

endpackage
